//--- testbench.sv
`include "wdt_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;
    // Stimulus
    logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic clearGuardInstr = 1'b0, haltInstr = 1'b0, resetPinLow = 1'b0;
    logic resetPinSelected = 1'b0, intRequest = 1'b0, intEnabled = 1'b1, stackFull = 1'b0;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0;
    logic [7:0]      portAPins = 8'hff;
    // Observed
    logic            pready, pslverr, chipReset, pcSpReset, wakeResume, wakeVector;
    logic            intPending, irq, ok;
    logic [31:0]     prdata, rd;
    power_state_type powerState;
    int              fail_count = 0;
    int              num_checks = 0;

    watchdog_and_wakeup_control u_dut (.*);

    always #5 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        ok = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdck(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // Irq is a register behind the status and mask registers
    task automatic irqck(input logic exp);
        repeat (2) @(posedge clk_sys);
        check("irq", irq, exp);
    endtask

    task automatic wait_ev(input bit wake);
        int n;
        n = 0;
        while ((wake ? (wakeResume | wakeVector) : chipReset) !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic halt();
        haltInstr <= 1'b1;
        @(posedge clk_sys);
        haltInstr <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdck("guard", `ADDR_GUARD_CTRL, 32'h53);
        rdck("flags", `ADDR_RESET_FLAGS, 32'h0);
        apb(1'b0, 12'h0ff, 32'h0);
        check("slverr", {31'h0, ok}, 32'h1);
        check("unmapped", rd, 32'h0);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
        apb(1'b1, `ADDR_GUARD_CTRL, 32'h3);
        wait_ev(1'b0);
        rdck("flags", `ADDR_RESET_FLAGS, 32'h1);
        irqck(1'b1);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
        irqck(1'b0);
        apb(1'b1, `ADDR_GUARD_CTRL, 32'hab);
        rdck("guard", `ADDR_GUARD_CTRL, 32'hab);
        rdck("flags", `ADDR_RESET_FLAGS, 32'h1);
        apb(1'b1, `ADDR_RESET_FLAGS, 32'h0);
        rdck("flags", `ADDR_RESET_FLAGS, 32'h0);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h2);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
        irqck(1'b0);
        apb(1'b1, `ADDR_WAKE_EN, 32'h1);
        apb(1'b1, `ADDR_MODE_CTRL, 32'h0);
        halt();
        check("state", powerState, SLEEP);
        rdck("status", `ADDR_STATUS, 32'h6);
        portAPins <= 8'hfd;
        repeat (10) @(posedge clk_sys);
        check("state", powerState, SLEEP);
        portAPins <= 8'hfc;
        wait_ev(1'b1);
        check("resume", wakeResume, 32'h1);
        portAPins <= 8'hff;
        repeat (3) @(posedge clk_sys);
        check("state", powerState, RUN);
        rdck("status", `ADDR_STATUS, 32'h2);
        clearGuardInstr <= 1'b1;
        @(posedge clk_sys);
        clearGuardInstr <= 1'b0;
        rdck("status", `ADDR_STATUS, 32'h0);
        apb(1'b1, `ADDR_MODE_CTRL, 32'h1);
        // Enabled with room, disabled, stack full
        for (int i = 0; i < 3; i++) begin
            intEnabled <= (i != 1);
            stackFull <= (i == 2);
            halt();
            check("state", powerState, IDLE);
            intRequest <= 1'b1;
            wait_ev(1'b1);
            check("vector", wakeVector, i == 0);
            repeat (2) @(posedge clk_sys);
            check("pending", intPending, i != 0);
            intRequest <= 1'b0;
            intEnabled <= 1'b1;
            stackFull <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        intRequest <= 1'b1;
        halt();
        repeat (20) @(posedge clk_sys);
        check("state", powerState, IDLE);
        intRequest <= 1'b0;
        portAPins <= 8'hfe;
        wait_ev(1'b1);
        check("resume", wakeResume, 32'h1);
        wrap_up();
    end
endmodule

bind watchdog_and_wakeup_control wdt_props u_props (.*);

//--- watchdog_and_wakeup_control.sv
`include "wdt_regs.svh"
module watchdog_and_wakeup_control (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic      [31:0]             prdata,
    output logic                         pslverr,
    // Core events
    input  wire logic                    clearGuardInstr,
    input  wire logic                    haltInstr,
    input  wire logic                    resetPinLow,
    input  wire logic                    resetPinSelected,
    input  wire logic                    intRequest,
    input  wire logic                    intEnabled,
    input  wire logic                    stackFull,
    input  wire logic [7:0]              portAPins,
    // Results
    output logic                         chipReset,
    output logic                         pcSpReset,
    output logic                         wakeResume,
    output logic                         wakeVector,
    output logic                         intPending,
    output wdt_pkg::power_state_type     powerState,
    output logic                         irq
);
    import wdt_pkg::*;

    logic [7:0]  guardCtrl_q;
    logic [3:0]  resetFlags_q;
    logic [7:0]  wakeEn_q;
    logic [1:0]  idleEn_q;
    logic        timeout_q;
    logic        powerDown_q;
    logic [2:0]  irqStatus_q;
    logic [2:0]  irqMask_q;
    logic [18:0] count_q;
    logic [11:0] tickDiv_q;
    logic [7:0]  srDelay_q;
    logic        illegalPend_q;
    logic [7:0]  pinPrev_q;
    logic        intBlocked_q;
    logic        ovf;
    logic        tick;
    logic        wrStrobe;
    logic [7:0]  pinFall;
    logic        intWake;
    logic        anyWake;
    logic        standby;
    logic [4:0]  guardEn;
    logic        illegalFire;
    logic        irqClear;
    logic [2:0]  irqEvent;
    logic        addrHit_d;
    logic [31:0] readData_d;

    function automatic logic [18:0] periodLimit(input logic [2:0] sel);
        case (sel)
            3'h0:    periodLimit = 19'h00100;
            3'h1:    periodLimit = 19'h00400;
            3'h2:    periodLimit = 19'h01000;
            3'h3:    periodLimit = 19'h04000;
            3'h4:    periodLimit = 19'h08000;
            3'h5:    periodLimit = 19'h10000;
            3'h6:    periodLimit = 19'h20000;
            default: periodLimit = 19'h40000;
        endcase
    endfunction

    function automatic logic isAddr(input logic [11:0] a, input logic [11:0] r);
        isAddr = (a == r);
    endfunction

    assign guardEn  = guardCtrl_q[7:`GUARD_EN_LSB];
    assign wrStrobe = psel & penable & pwrite;
    assign tick     = (tickDiv_q == 12'(`LOW_SPEED_RC_OSC_TICK_CYCLES - 1));
    assign ovf      = tick & (guardEn == `GUARD_CODE_ENABLE)
                    & (count_q == periodLimit(guardCtrl_q[2:0]) - 19'h1);
    assign standby  = (powerState != RUN);
    assign pinFall  = pinPrev_q & ~portAPins & wakeEn_q;
    assign intWake  = intRequest & ~intBlocked_q;
    assign anyWake  = standby & ((|pinFall) | intWake | ovf
                    | (resetPinSelected & resetPinLow));
    assign illegalFire = illegalPend_q & (srDelay_q == 8'h00);
    assign irqClear    = wrStrobe & isAddr(paddr, `ADDR_IRQ_STATUS);
    assign irqEvent[`IRQ_TIMEOUT_BIT] = ovf;
    assign irqEvent[`IRQ_ILLEGAL_BIT] = illegalFire;
    assign irqEvent[`IRQ_WAKE_BIT]    = anyWake;

    // Low-speed tick derived from the system clock; the real RC source is approximate anyway
    always_ff @(posedge clk_sys) begin
        if (reset || tick) begin
            tickDiv_q <= 12'h000;
        end else begin
            tickDiv_q <= tickDiv_q + 12'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_q <= 19'h00000;
        end else if (illegalPend_q || clearGuardInstr || haltInstr
                     || (resetPinSelected && resetPinLow)) begin
            count_q <= 19'h00000;
        end else if (ovf) begin
            count_q <= 19'h00000;
        end else if (tick && guardEn == `GUARD_CODE_ENABLE) begin
            count_q <= count_q + 19'h00001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            guardCtrl_q <= `GUARD_CTRL_RESET;
        end else if (wrStrobe && isAddr(paddr, `ADDR_GUARD_CTRL)) begin
            guardCtrl_q <= pwdata[7:0];
        end
    end

    // Illegal code holds off the chip reset for the software-reset delay
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            illegalPend_q <= 1'b0;
            srDelay_q     <= 8'h00;
        end else if (guardEn != `GUARD_CODE_ENABLE && guardEn != `GUARD_CODE_DISABLE
                     && !illegalPend_q) begin
            illegalPend_q <= 1'b1;
            srDelay_q     <= 8'(`SRESET_CYCLES);
        end else if (illegalPend_q && srDelay_q != 8'h00) begin
            srDelay_q <= srDelay_q - 8'h01;
        end else begin
            illegalPend_q <= 1'b0;
        end
    end

    // Guard control reset flag: hardware only sets, software only clears; it survives chipReset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resetFlags_q <= 4'h0;
        end else if (illegalPend_q && srDelay_q == 8'h00) begin
            resetFlags_q[0] <= 1'b1;
        end else if (wrStrobe && isAddr(paddr, `ADDR_RESET_FLAGS)) begin
            resetFlags_q <= resetFlags_q & pwdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wakeEn_q <= 8'h00;
        end else if (wrStrobe && isAddr(paddr, `ADDR_WAKE_EN)) begin
            wakeEn_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            idleEn_q <= 2'h0;
        end else if (wrStrobe && isAddr(paddr, `ADDR_MODE_CTRL)) begin
            idleEn_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqMask_q <= 3'h0;
        end else if (wrStrobe && isAddr(paddr, `ADDR_IRQ_MASK)) begin
            irqMask_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            powerState <= RUN;
        end else begin
            case (powerState)
                RUN: begin
                    if (haltInstr) begin
                        powerState <= (idleEn_q == 2'h0) ? SLEEP : IDLE;
                    end
                end
                default: begin
                    if (anyWake) begin
                        powerState <= RUN;
                    end
                end
            endcase
        end
    end

    // A request already up at halt cannot wake until it has dropped once
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            intBlocked_q <= 1'b0;
        end else if (haltInstr && !standby) begin
            intBlocked_q <= intRequest;
        end else if (!intRequest) begin
            intBlocked_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timeout_q <= 1'b0;
        end else if (ovf) begin
            timeout_q <= 1'b1;
        end else if (haltInstr || clearGuardInstr) begin
            timeout_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            powerDown_q <= 1'b0;
        end else if (haltInstr) begin
            powerDown_q <= 1'b1;
        end else if (clearGuardInstr) begin
            powerDown_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinPrev_q <= 8'hff;
        end else begin
            pinPrev_q <= portAPins;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chipReset <= 1'b0;
        end else begin
            chipReset <= (ovf && !standby) || illegalFire;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pcSpReset <= 1'b0;
        end else begin
            pcSpReset <= ovf && standby;
        end
    end

    // A pin edge wins over an interrupt that arrives in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wakeResume <= 1'b0;
        end else begin
            wakeResume <= anyWake && !ovf && ((|pinFall)
                          || (intWake && (!intEnabled || stackFull)));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wakeVector <= 1'b0;
        end else begin
            wakeVector <= anyWake && !ovf && !(|pinFall)
                          && intWake && intEnabled && !stackFull;
        end
    end

    // Pending follows the request while the core cannot service it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            intPending <= 1'b0;
        end else begin
            intPending <= intRequest && (!intEnabled || stackFull);
        end
    end

    // Sticky bits: an event in the clearing cycle wins so none is lost
    generate
        for (genvar g = 0; g < 3; g++) begin : g_irq
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    irqStatus_q[g] <= 1'b0;
                end else if (irqEvent[g]) begin
                    irqStatus_q[g] <= 1'b1;
                end else if (irqClear && pwdata[g]) begin
                    irqStatus_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    always_comb begin
        readData_d = 32'h00000000;
        addrHit_d  = 1'b1;
        if (isAddr(paddr, `ADDR_GUARD_CTRL)) begin
            readData_d[7:0] = guardCtrl_q;
        end else if (isAddr(paddr, `ADDR_RESET_FLAGS)) begin
            readData_d[3:0] = resetFlags_q;
        end else if (isAddr(paddr, `ADDR_WAKE_EN)) begin
            readData_d[7:0] = wakeEn_q;
        end else if (isAddr(paddr, `ADDR_MODE_CTRL)) begin
            readData_d[1:0] = idleEn_q;
        end else if (isAddr(paddr, `ADDR_STATUS)) begin
            readData_d[3:0] = {powerState, powerDown_q, timeout_q};
        end else if (isAddr(paddr, `ADDR_IRQ_STATUS)) begin
            readData_d[2:0] = irqStatus_q;
        end else if (isAddr(paddr, `ADDR_IRQ_MASK)) begin
            readData_d[2:0] = irqMask_q;
        end else begin
            addrHit_d = 1'b0;
        end
    end

    // No wait state; read data is still registered
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addrHit_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= readData_d;
        end
    end
endmodule

//--- wdt_pkg.sv
package wdt_pkg;
    typedef enum logic [1:0] {RUN, SLEEP, IDLE} power_state_type;
    typedef enum logic [1:0] {WAKE_NONE, WAKE_RESUME, WAKE_VECTOR, WAKE_TIMEOUT} wake_kind_type;
endpackage

//--- wdt_props.sv
module wdt_props (
    // Clock and reset
    input wire logic                     clk_sys,
    input wire logic                     reset,
    // Bus
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // Core side
    input wire logic                     haltInstr,
    input wire logic                     intEnabled,
    input wire logic                     chipReset,
    input wire logic                     pcSpReset,
    input wire logic                     wakeResume,
    input wire logic                     wakeVector,
    input wire wdt_pkg::power_state_type powerState
);
    import wdt_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held");
    slverr_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    halt_leaves_run_a: assert property (haltInstr && powerState == RUN |-> ##[1:2] powerState != RUN)
        else $error("halt ignored");
    wake_from_standby_a: assert property ($rose(wakeResume | wakeVector) |-> $past(powerState) != RUN)
        else $error("wake in run");
    vector_needs_enable_a: assert property (wakeVector |-> $past(intEnabled))
        else $error("vector while disabled");
    wake_one_kind_a: assert property (!(wakeResume && wakeVector))
        else $error("two wake kinds");
    wake_back_run_a: assert property (wakeResume || wakeVector |-> ##[0:1] powerState == RUN)
        else $error("no return to run");
    pcsp_only_standby_a: assert property (pcSpReset |-> $past(powerState) != RUN && !chipReset)
        else $error("pc reset in run");
    // Delayed reset repeats, but never again within the next eight cycles
    chip_reset_spaced_a: assert property (chipReset |=> !chipReset [*8])
        else $error("chip reset too close");
endmodule

//--- wdt_regs.svh
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define ADDR_GUARD_CTRL    12'h000
`define ADDR_RESET_FLAGS   12'h004
`define ADDR_WAKE_EN       12'h008
`define ADDR_MODE_CTRL     12'h00c
`define ADDR_STATUS        12'h010
`define ADDR_IRQ_STATUS    12'h014
`define ADDR_IRQ_MASK      12'h018
`define GUARD_CTRL_RESET   8'h53
`define GUARD_CODE_ENABLE  5'h0a
`define GUARD_CODE_DISABLE 5'h15
`define GUARD_EN_LSB       3
`define PERIOD_RESET       3'h3
`define LOW_SPEED_RC_OSC_TICK_NS       31250
`define CLK_PERIOD_NS      10
`define LOW_SPEED_RC_OSC_TICK_CYCLES   (`LOW_SPEED_RC_OSC_TICK_NS / `CLK_PERIOD_NS)
`define SRESET_NS          1000
`define SRESET_CYCLES      ((`SRESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_TIMEOUT_BIT    0
`define IRQ_ILLEGAL_BIT    1
`define IRQ_WAKE_BIT       2
`endif
